// ---- common/tsb_params.svh ----
// Constants for the trap, system-call and breakpoint exception unit.
// Assumes a 32-bit instruction word and a 64-bit address path.
`ifndef TSB_PARAMS_SVH
`define TSB_PARAMS_SVH

// Register byte offsets on the AXI4-Lite slave.
`define TSB_OFF_VECTOR_LO    8'h00
`define TSB_OFF_VECTOR_HI    8'h04
`define TSB_OFF_STATUS       8'h08
`define TSB_OFF_MASK         8'h0c
`define TSB_OFF_RET_LO       8'h10
`define TSB_OFF_RET_HI       8'h14
`define TSB_OFF_REASON       8'h18
`define TSB_OFF_INSTR        8'h1c

// Reason codes written to the reason field.
`define TSB_REASON_NONE      5'h00
`define TSB_REASON_SVC       5'h08
`define TSB_REASON_BREAK     5'h09
`define TSB_REASON_TRAP      5'h0d

// Field positions in the reason register.
`define TSB_REASON_DS_BIT    31
`define TSB_REASON_LSB       2

// Status bit positions.
`define TSB_ST_TRAP          0
`define TSB_ST_SVC           1
`define TSB_ST_BREAK         2

// Reset value of the common exception vector.
`define TSB_VECTOR_RESET     64'hffff_ffff_8000_0180

// Instruction encoding fields.
`define TSB_OP_SPECIAL       6'h00
`define TSB_OP_REGIMM        6'h01
`define TSB_FN_SVC           6'h0c
`define TSB_FN_BREAK         6'h0d
`define TSB_FN_GE            6'h30
`define TSB_FN_GEU           6'h31
`define TSB_FN_LT            6'h32
`define TSB_FN_LTU           6'h33
`define TSB_FN_EQ            6'h34
`define TSB_FN_NE            6'h36
`define TSB_RI_GEI           5'h08
`define TSB_RI_GEUI          5'h09
`define TSB_RI_LTI           5'h0a
`define TSB_RI_LTUI          5'h0b
`define TSB_RI_EQI           5'h0c
`define TSB_RI_NEI           5'h0e

`endif

// ---- common/tsb_pkg.sv ----
// Types shared by the exception unit and its bench.
// Assumes the constants header is included where numbers are needed.
`default_nettype none
package tsb_pkg;
    typedef struct packed {
        logic        valid;
        logic [31:0] instr;
        logic [63:0] pc;
        logic        in_delay_slot;
        logic [63:0] branch_pc;
        logic [63:0] rs_val;
        logic [63:0] rt_val;
    } tsb_commit_t;

    typedef struct packed {
        logic        take;
        logic [63:0] vector;
    } tsb_redirect_t;

    typedef enum logic [1:0] {
        TSB_KIND_NONE    = 2'b00,
        TSB_KIND_TRAP    = 2'b01,
        TSB_KIND_SVC     = 2'b10,
        TSB_KIND_BREAK   = 2'b11
    } tsb_kind_t;
endpackage : tsb_pkg
`default_nettype wire

// ---- design/tsb_exc_unit.sv ----
// Trap, system-call and breakpoint exception detection and recording.
// Assumes the pipeline presents its oldest instruction at commit with operands and
// a flush request back; AXI4-Lite master follows the usual valid/ready handshake.
`include "tsb_params.svh"
`default_nettype none
module tsb_exc_unit (
    // Clock and reset
    input  wire logic                clock,
    input  wire logic                nrst,
    // Commit stage
    input  wire tsb_pkg::tsb_commit_t commit_i,
    output var  logic                commit_ok_o,
    output var  logic                flush_o,
    output var  tsb_pkg::tsb_redirect_t redirect_o,
    // Recorded exception state
    output var  logic [63:0]         exception_return_address,
    output var  logic                delay_slot_flag,
    output var  logic [4:0]          reason_code,
    // Interrupt
    output var  logic                irq_o,
    // AXI4-Lite slave
    input  wire logic [7:0]          s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output var  logic                s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output var  logic                s_axi_wready,
    output var  logic [1:0]          s_axi_bresp,
    output var  logic                s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [7:0]          s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output var  logic                s_axi_arready,
    output var  logic [31:0]         s_axi_rdata,
    output var  logic [1:0]          s_axi_rresp,
    output var  logic                s_axi_rvalid,
    input  wire logic                s_axi_rready
);
    logic [5:0]        opcode;
    logic [5:0]        funct;
    logic [4:0]        regimm_sel;
    logic [63:0]       imm_sx;
    logic [63:0]       cmp_b;
    logic              cmp_ge;
    logic              cmp_geu;
    logic              cmp_eq;
    logic              trap_hit;
    tsb_pkg::tsb_kind_t kind;
    logic              take;
    logic [63:0]       vector_q;
    logic [2:0]        status_q;
    logic [2:0]        mask_q;
    logic [2:0]        status_set;
    logic [2:0]        status_clr;
    logic [31:0]       instr_q;
    logic [7:0]        awaddr_q;
    logic [31:0]       wdata_q;
    logic [3:0]        wstrb_q;
    logic              aw_have_q;
    logic              w_have_q;
    logic              wr_fire;
    logic [31:0]       rd_word;
    logic [2:0]        status_nx;
    logic              rd_ok;

    // Only opcode, function, regimm and immediate fields are decoded; the code field is never decoded here.
    assign opcode     = commit_i.instr[31:26];
    assign funct      = commit_i.instr[5:0];
    assign regimm_sel = commit_i.instr[20:16];
    assign imm_sx     = {{48{commit_i.instr[15]}}, commit_i.instr[15:0]};
    assign cmp_b      = (opcode == `TSB_OP_REGIMM) ? imm_sx : commit_i.rt_val;
    assign cmp_ge     = $signed(commit_i.rs_val) >= $signed(cmp_b);
    assign cmp_geu    = commit_i.rs_val >= cmp_b;
    assign cmp_eq     = commit_i.rs_val == cmp_b;

    always_comb begin
        trap_hit = 1'b0;
        if (opcode == `TSB_OP_SPECIAL) begin
            unique case (funct)
                `TSB_FN_GE:  trap_hit = cmp_ge;
                `TSB_FN_GEU: trap_hit = cmp_geu;
                `TSB_FN_LT:  trap_hit = !cmp_ge;
                `TSB_FN_LTU: trap_hit = !cmp_geu;
                `TSB_FN_EQ:  trap_hit = cmp_eq;
                `TSB_FN_NE:  trap_hit = !cmp_eq;
                default:     trap_hit = 1'b0;
            endcase
        end else if (opcode == `TSB_OP_REGIMM) begin
            unique case (regimm_sel)
                `TSB_RI_GEI:  trap_hit = cmp_ge;
                `TSB_RI_GEUI: trap_hit = cmp_geu;
                `TSB_RI_LTI:  trap_hit = !cmp_ge;
                `TSB_RI_LTUI: trap_hit = !cmp_geu;
                `TSB_RI_EQI:  trap_hit = cmp_eq;
                `TSB_RI_NEI:  trap_hit = !cmp_eq;
                default:      trap_hit = 1'b0;
            endcase
        end
    end

    // A supervisor call outranks a breakpoint, and both outrank a true compare.
    always_comb begin
        kind = tsb_pkg::TSB_KIND_NONE;
        if (commit_i.valid) begin
            if (opcode == `TSB_OP_SPECIAL && funct == `TSB_FN_SVC) begin
                kind = tsb_pkg::TSB_KIND_SVC;
            end else if (opcode == `TSB_OP_SPECIAL && funct == `TSB_FN_BREAK) begin
                kind = tsb_pkg::TSB_KIND_BREAK;
            end else if (trap_hit) begin
                kind = tsb_pkg::TSB_KIND_TRAP;
            end
        end
    end

    // No mask sits in this path: all three kinds are unmaskable.
    assign take = kind != tsb_pkg::TSB_KIND_NONE;

    // A faulting instruction is never acknowledged, so it and younger ones are flushed.
    always_ff @(posedge clock) begin
        if (!nrst) begin
            commit_ok_o <= 1'b0;
            flush_o     <= 1'b0;
        end else begin
            commit_ok_o <= commit_i.valid && !take;
            flush_o     <= take;
        end
    end

    // The vector is copied every cycle, so a rewrite takes effect at the next exception.
    always_ff @(posedge clock) begin
        if (!nrst) begin
            redirect_o <= '0;
        end else begin
            redirect_o.take   <= take;
            redirect_o.vector <= vector_q;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            exception_return_address <= 64'h0;
            delay_slot_flag          <= 1'b0;
            reason_code              <= `TSB_REASON_NONE;
        end else if (take) begin
            exception_return_address <= commit_i.in_delay_slot ? commit_i.branch_pc
                                                               : commit_i.pc;
            delay_slot_flag <= commit_i.in_delay_slot;
            unique case (kind)
                tsb_pkg::TSB_KIND_TRAP:  reason_code <= `TSB_REASON_TRAP;
                tsb_pkg::TSB_KIND_SVC:   reason_code <= `TSB_REASON_SVC;
                tsb_pkg::TSB_KIND_BREAK: reason_code <= `TSB_REASON_BREAK;
                tsb_pkg::TSB_KIND_NONE:  reason_code <= reason_code;
            endcase
        end
    end

    // The whole word is kept, since only the handler decodes the code field.
    always_ff @(posedge clock) begin
        if (!nrst) begin
            instr_q <= 32'h0;
        end else if (take) begin
            instr_q <= commit_i.instr;
        end
    end

    // Sticky event bits; a new event wins over a write-one-to-clear in the same cycle.
    assign status_set = {kind == tsb_pkg::TSB_KIND_BREAK,
                         kind == tsb_pkg::TSB_KIND_SVC,
                         kind == tsb_pkg::TSB_KIND_TRAP};
    assign status_clr = (wr_fire && awaddr_q == `TSB_OFF_STATUS && wstrb_q[0])
                        ? wdata_q[2:0] : 3'h0;
    assign status_nx  = (status_q & ~status_clr) | status_set;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            status_q <= 3'h0;
        end else begin
            status_q <= status_nx;
        end
    end

    // Built from the next status, so the request rises in the same cycle as its bit.
    always_ff @(posedge clock) begin
        if (!nrst) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(status_nx & mask_q);
        end
    end

    // Write channel: address and data may arrive in either order.
    assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            awaddr_q      <= 8'h0;
            wdata_q       <= 32'h0;
            wstrb_q       <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
        end else begin
            s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_have_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                unique case (awaddr_q)
                    `TSB_OFF_VECTOR_LO, `TSB_OFF_VECTOR_HI,
                    `TSB_OFF_STATUS, `TSB_OFF_MASK: s_axi_bresp <= 2'h0;
                    default:                        s_axi_bresp <= 2'h2;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Software-steered registers: vector and mask.
    always_ff @(posedge clock) begin
        if (!nrst) begin
            vector_q <= `TSB_VECTOR_RESET;
            mask_q   <= 3'h0;
        end else if (wr_fire) begin
            for (int b = 0; b < 4; b++) begin
                if (wstrb_q[b]) begin
                    if (awaddr_q == `TSB_OFF_VECTOR_LO) begin
                        vector_q[b*8 +: 8] <= wdata_q[b*8 +: 8];
                    end
                    if (awaddr_q == `TSB_OFF_VECTOR_HI) begin
                        vector_q[32 + b*8 +: 8] <= wdata_q[b*8 +: 8];
                    end
                end
            end
            if (awaddr_q == `TSB_OFF_MASK && wstrb_q[0]) begin
                mask_q <= wdata_q[2:0];
            end
        end
    end

    always_comb begin
        rd_word = 32'h0;
        unique case (s_axi_araddr)
            `TSB_OFF_VECTOR_LO: rd_word = vector_q[31:0];
            `TSB_OFF_VECTOR_HI: rd_word = vector_q[63:32];
            `TSB_OFF_STATUS:    rd_word = {29'h0, status_q};
            `TSB_OFF_MASK:      rd_word = {29'h0, mask_q};
            `TSB_OFF_RET_LO:    rd_word = exception_return_address[31:0];
            `TSB_OFF_RET_HI:    rd_word = exception_return_address[63:32];
            `TSB_OFF_REASON:    rd_word = {delay_slot_flag, 24'h0, reason_code, 2'h0};
            `TSB_OFF_INSTR:     rd_word = instr_q;
            default:            rd_word = 32'h0;
        endcase
    end

    // Any aligned word up to the captured instruction reads back; the rest is an error.
    assign rd_ok = s_axi_araddr[1:0] == 2'h0 && s_axi_araddr <= `TSB_OFF_INSTR;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= 2'h0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule : tsb_exc_unit
`default_nettype wire

// ---- dv/tsb_exc_chk.sv ----
// Concurrent checks on the exception unit's commit-side ports.
// Assumes the single clock and the synchronous active-low reset of the unit.
`include "tsb_params.svh"
`default_nettype none
module tsb_exc_chk (
    // Clock and reset
    input wire logic                   clock,
    input wire logic                   nrst,
    // Commit stage
    input wire tsb_pkg::tsb_commit_t   commit_i,
    input wire logic                   commit_ok_o,
    input wire logic                   flush_o,
    input wire tsb_pkg::tsb_redirect_t redirect_o,
    // Recorded exception state
    input wire logic [63:0]            exception_return_address,
    input wire logic                   delay_slot_flag,
    input wire logic [4:0]             reason_code
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);
    logic spec, same, sys, brk, eq_hit, ne_miss, exc;
    // Only system calls, breakpoints and the register-form equal and unequal tests are decoded here; the bench model covers the rest.
    assign spec = commit_i.valid && commit_i.instr[31:26] == `TSB_OP_SPECIAL;
    assign same = commit_i.rs_val == commit_i.rt_val;
    assign sys = spec && commit_i.instr[5:0] == `TSB_FN_SVC;
    assign brk = spec && commit_i.instr[5:0] == `TSB_FN_BREAK;
    assign eq_hit = spec && commit_i.instr[5:0] == `TSB_FN_EQ && same;
    assign ne_miss = spec && commit_i.instr[5:0] == `TSB_FN_NE && same;
    assign exc = sys || brk || eq_hit;
    sequence s_taken;
        flush_o && redirect_o.take && !commit_ok_o;
    endsequence
    a_sys_taken: assert property (sys |=> s_taken ##0 reason_code == `TSB_REASON_SVC)
        else $error("system call not taken with its reason");
    a_brk_taken: assert property (brk |=> s_taken ##0 reason_code == `TSB_REASON_BREAK)
        else $error("breakpoint not taken with its reason");
    a_eq_taken: assert property (eq_hit |=> s_taken ##0 reason_code == `TSB_REASON_TRAP)
        else $error("true equal test did not trap");
    a_ne_pass: assert property (ne_miss |=> commit_ok_o && !flush_o)
        else $error("false unequal test trapped");
    a_ret_addr: assert property (exc |=> exception_return_address ==
        ($past(commit_i.in_delay_slot) ? $past(commit_i.branch_pc) : $past(commit_i.pc)))
        else $error("return address wrong");
    a_slot_flag: assert property (exc |=> delay_slot_flag == $past(commit_i.in_delay_slot))
        else $error("delay slot flag wrong");
    a_take_pair: assert property (redirect_o.take == flush_o)
        else $error("redirect and flush disagree");
    a_regs_hold: assert property (!flush_o |-> $stable(exception_return_address))
        else $error("return address moved without an exception");
    a_idle_quiet: assert property (!commit_i.valid |=> !commit_ok_o && !flush_o)
        else $error("output pulse without a commit");
endmodule : tsb_exc_chk
bind tsb_exc_unit tsb_exc_chk u_chk (.clock(clock), .nrst(nrst), .commit_i(commit_i),
    .commit_ok_o(commit_ok_o), .flush_o(flush_o), .redirect_o(redirect_o),
    .exception_return_address(exception_return_address),
    .delay_slot_flag(delay_slot_flag), .reason_code(reason_code));
`default_nettype wire

// ---- dv/test_trap_supervisor_call_instruction_break_exceptions.sv ----
// Self-checking bench: random commits against a reference model, then register traffic.
// Assumes the unit and its checker are compiled ahead of this file.
`include "tsb_params.svh"
`default_nettype none
module test_trap_supervisor_call_instruction_break_exceptions;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock, nrst, commit_ok_o, flush_o, delay_slot_flag, irq_o;
    tsb_pkg::tsb_commit_t commit_i, prev, c;
    tsb_pkg::tsb_redirect_t redirect_o;
    logic [63:0] exception_return_address;
    logic [4:0] reason_code;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int n_fail = 0;
    int check_count = 0;
    logic [31:0] seed = 32'h36832e0f;
    logic [63:0] m_vec = `TSB_VECTOR_RESET;
    logic [63:0] m_ret = 64'h0;
    logic m_flag = 1'h0;
    logic [4:0] m_reason = 5'h0;
    logic [2:0] m_stat = 3'h0;
    logic [5:0] fns [9] = '{`TSB_FN_SVC, `TSB_FN_BREAK, `TSB_FN_GE, `TSB_FN_GEU,
        `TSB_FN_LT, `TSB_FN_LTU, `TSB_FN_EQ, `TSB_FN_NE, 6'h20};
    logic [4:0] ris [6] = '{`TSB_RI_GEI, `TSB_RI_GEUI, `TSB_RI_LTI, `TSB_RI_LTUI,
        `TSB_RI_EQI, `TSB_RI_NEI};
    tsb_exc_unit u_dut (
        .clock(clock), .nrst(nrst), .commit_i(commit_i), .commit_ok_o(commit_ok_o),
        .flush_o(flush_o), .redirect_o(redirect_o), .irq_o(irq_o),
        .exception_return_address(exception_return_address),
        .delay_slot_flag(delay_slot_flag), .reason_code(reason_code),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
    initial begin
        clock = 1'h0;
        forever #50 clock = ~clock;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : wrap_up
    task automatic chk(string n, logic [63:0] e, logic [63:0] g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    function automatic logic [4:0] exp_reason(tsb_pkg::tsb_commit_t k);
        logic signed [63:0] a, b;
        logic [5:0] f;
        logic t;
        a = k.rs_val;
        b = k.rt_val;
        f = k.instr[5:0];
        if (k.instr[31:26] == `TSB_OP_REGIMM) begin
            b = {{48{k.instr[15]}}, k.instr[15:0]};
            f = {3'h6, k.instr[18:16]};
        end else if (f == `TSB_FN_SVC) return `TSB_REASON_SVC;
        else if (f == `TSB_FN_BREAK) return `TSB_REASON_BREAK;
        case (f)
            `TSB_FN_GE: t = a >= b;
            `TSB_FN_GEU: t = $unsigned(a) >= $unsigned(b);
            `TSB_FN_LT: t = a < b;
            `TSB_FN_LTU: t = $unsigned(a) < $unsigned(b);
            `TSB_FN_EQ: t = a == b;
            `TSB_FN_NE: t = a != b;
            default: t = 1'h0;
        endcase
        return t ? `TSB_REASON_TRAP : `TSB_REASON_NONE;
    endfunction : exp_reason
    function automatic tsb_pkg::tsb_commit_t rand_commit();
        tsb_pkg::tsb_commit_t k;
        logic [31:0] r, x;
        int i;
        r = rnd();
        x = rnd();
        i = r[7:0] % 15;
        k.valid = r[8] | r[9];
        k.in_delay_slot = r[10];
        k.pc = {rnd(), x & 32'hffff_fffc};
        k.branch_pc = k.pc - 64'h4;
        if (i < 9) k.instr = {`TSB_OP_SPECIAL, x[25:6], fns[i]};
        else k.instr = {`TSB_OP_REGIMM, x[25:21], ris[i - 9], x[15:0]};
        k.rs_val = r[11] ? {{48{x[15]}}, x[15:0]} : {rnd(), rnd()};
        k.rt_val = r[12] ? k.rs_val : {rnd(), rnd()};
        return k;
    endfunction : rand_commit
    task automatic check_commit(tsb_pkg::tsb_commit_t k);
        logic [4:0] e;
        logic ex;
        e = k.valid ? exp_reason(k) : `TSB_REASON_NONE;
        ex = e != `TSB_REASON_NONE;
        if (ex) begin
            // The raw address is kept; stepping past the instruction is the handler's job.
            m_ret = k.in_delay_slot ? k.branch_pc : k.pc;
            m_flag = k.in_delay_slot;
            m_reason = e;
            m_stat |= e == `TSB_REASON_TRAP ? 3'h1 : (e == `TSB_REASON_SVC ? 3'h2 : 3'h4);
        end
        chk("flush", ex, flush_o);
        chk("take", ex, redirect_o.take);
        chk("commit_ok", k.valid && !ex, commit_ok_o);
        if (ex) chk("vector", m_vec, redirect_o.vector);
        chk("ret_addr", m_ret, exception_return_address);
        chk("slot_flag", m_flag, delay_slot_flag);
        chk("reason", m_reason, reason_code);
    endtask : check_commit
    // Drives one commit and checks the answer to the one before it, one per cycle.
    task automatic commit_one(tsb_pkg::tsb_commit_t k);
        @(posedge clock);
        commit_i <= k;
        @(negedge clock);
        check_commit(prev);
        prev = k;
    endtask : commit_one
    task automatic axi_wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
        int i;
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (i = 0; i < 50 && !s_axi_bvalid; i++) begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end
        s_axi_bready <= 1'h0;
        if (i == 50) n_fail++;
        if (i == 50) wrap_up();
        chk("bresp", er, s_axi_bresp);
    endtask : axi_wr
    task automatic axi_rd(logic [7:0] a);
        int i;
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (i = 0; i < 50 && !s_axi_rvalid; i++) begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'h0;
        if (i == 50) n_fail++;
        if (i == 50) wrap_up();
    endtask : axi_rd
    initial begin
        {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {commit_i, prev, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        repeat (8) @(posedge clock);
        nrst <= 1'h1;
        axi_rd(`TSB_OFF_VECTOR_LO);
        chk("vector_lo", m_vec[31:0], rd);
        repeat (600) commit_one(rand_commit());
        commit_one('0);
        $display("random commit test done");
        axi_rd(`TSB_OFF_STATUS);
        chk("status", m_stat, rd);
        chk("irq_masked", 1'h0, irq_o);
        axi_wr(`TSB_OFF_MASK, 32'h7, 2'h0);
        repeat (3) @(negedge clock);
        chk("irq_raised", |m_stat, irq_o);
        axi_wr(`TSB_OFF_STATUS, {29'h0, m_stat}, 2'h0);
        m_stat = 3'h0;
        repeat (3) @(negedge clock);
        chk("irq_cleared", 1'h0, irq_o);
        axi_rd(8'h20);
        chk("unmapped_resp", 2'h2, rr);
        axi_wr(`TSB_OFF_RET_LO, 32'h1, 2'h2);
        $display("register and interrupt test done");
        axi_wr(`TSB_OFF_VECTOR_LO, 32'h0000_0200, 2'h0);
        m_vec[31:0] = 32'h0000_0200;
        c = '{1'h1, {`TSB_OP_SPECIAL, 20'hfffff, `TSB_FN_SVC}, 64'h40, 1'h1, 64'h3c,
            64'h0, 64'h0};
        commit_one(c);
        commit_one('0);
        axi_rd(`TSB_OFF_REASON);
        chk("reason_reg", {m_flag, 24'h0, m_reason, 2'h0}, rd);
        axi_rd(`TSB_OFF_RET_LO);
        chk("ret_lo", m_ret[31:0], rd);
        $display("vector and delay slot test done");
        wrap_up();
    end
endmodule : test_trap_supervisor_call_instruction_break_exceptions
`default_nettype wire
